// [rtl/lcft_divider.sv]
// Tap-selectable prescaler followed by the 1-to-8 clock divider
`timescale 1ns/1ps
module lcft_divider (
    input wire logic hclk,
    input wire logic hresetn,
    lcft_tick_if.div tk
);
    logic [11:0] presc_q;
    logic [2:0] div_q;
    logic period_start_q;
    logic half_point_q;
    logic [15:0] n_val;
    logic [15:0] elapsed;
    logic [15:0] half_val;
    logic presc_wrap;
    logic div_wrap;

    always_comb begin
        n_val = lcft_pkg::tap_ratio(tk.tap_sel);
        elapsed = {13'h0000, div_q} * n_val + {4'h0, presc_q};
        half_val = 16'((n_val * ({13'h0000, tk.div_sel} + 16'h0001)) >> 1);
        presc_wrap = ({4'h0, presc_q} == n_val - 16'h0001);
        div_wrap = (div_q >= tk.div_sel);
    end

    // Prescaler and divider counters, cleared while the display is off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_q <= 12'h000;
            div_q <= 3'h0;
        end else if (tk.clear) begin
            presc_q <= 12'h000;
            div_q <= 3'h0;
        end else if (tk.src_tick) begin
            if (presc_wrap) begin
                presc_q <= 12'h000;
                div_q <= div_wrap ? 3'h0 : div_q + 3'h1;
            end else begin
                presc_q <= presc_q + 12'h001;
            end
        end
    end

    // One pulse per prescaled period, and one at its midpoint
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            period_start_q <= 1'b0;
            half_point_q <= 1'b0;
        end else begin
            period_start_q <= !tk.clear && tk.src_tick && presc_wrap && div_wrap;
            half_point_q <= !tk.clear && tk.src_tick && (elapsed + 16'h0001 == half_val);
        end
    end

    assign tk.period_start = period_start_q;
    assign tk.half_point = half_point_q;
endmodule // lcft_divider

// [rtl/lcft_pkg.sv]
// Constants, field layout and timing counts for the display frame timing block
package lcft_pkg;

    // Bus clock period
    localparam int unsigned CLK_PERIOD_NS = 25;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_FRAME_RATE = 10'h0E6;
    localparam logic [9:0] IDX_DRIVE_CONTRAST = 10'h0E7;
    localparam logic [9:0] IDX_CONTROL = 10'h0E8;
    localparam logic [11:0] ADDR_FRAME_RATE = {IDX_FRAME_RATE, 2'b00};
    localparam logic [11:0] ADDR_DRIVE_CONTRAST = {IDX_DRIVE_CONTRAST, 2'b00};
    localparam logic [11:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};

    // Reset values and writable bits
    localparam logic [7:0] FRAME_RATE_RST = 8'h00;
    localparam logic [7:0] DRIVE_CONTRAST_RST = 8'h00;
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] FRAME_RATE_WMASK = 8'h77;
    localparam logic [7:0] DRIVE_CONTRAST_WMASK = 8'hEF;
    localparam logic [7:0] CONTROL_WMASK = 8'h1F;

    // Field positions
    localparam int unsigned TAP_LSB = 4;
    localparam int unsigned DIV_LSB = 0;
    localparam int unsigned DRV_LSB = 5;
    localparam int unsigned CON_LSB = 0;
    localparam int unsigned CT_ENABLE = 0;
    localparam int unsigned CT_BLANK = 1;
    localparam int unsigned CT_DUTY_LSB = 2;
    localparam int unsigned CT_SOURCE = 4;
    localparam int unsigned CT_BLANKED = 7;

    // Duty codes and frame length factors
    localparam logic [1:0] DUTY_STATIC = 2'h0;
    localparam logic [1:0] DUTY_THIRD = 2'h2;
    localparam logic [3:0] FRAME_K_DEFAULT = 4'h8;
    localparam logic [3:0] FRAME_K_THIRD = 4'h6;

    // Nominal driver on-times in microseconds, and the half-period code
    localparam int unsigned DRV_US_C0 = 300;
    localparam int unsigned DRV_US_C1 = 70;
    localparam int unsigned DRV_US_C2 = 150;
    localparam int unsigned DRV_US_C3 = 450;
    localparam int unsigned DRV_US_C4 = 575;
    localparam int unsigned DRV_US_C5 = 850;
    localparam int unsigned DRV_US_C6 = 1150;
    localparam logic [2:0] DRV_HALF_CODE = 3'h7;

    // Least times round up to whole cycles
    localparam int unsigned DRV_CYC_C0 = (DRV_US_C0 * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DRV_CYC_C1 = (DRV_US_C1 * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DRV_CYC_C2 = (DRV_US_C2 * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DRV_CYC_C3 = (DRV_US_C3 * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DRV_CYC_C4 = (DRV_US_C4 * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DRV_CYC_C5 = (DRV_US_C5 * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DRV_CYC_C6 = (DRV_US_C6 * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // AHB transfer type
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // Prescaler tap ratio N for a tap code
    function automatic logic [15:0] tap_ratio(input logic [2:0] sel);
        logic [15:0] n;
        n = 16'h0000;
        case (sel)
            3'h0: n = 16'h0010;
            3'h1: n = 16'h0040;
            3'h2: n = 16'h0080;
            3'h3: n = 16'h0100;
            3'h4: n = 16'h0200;
            3'h5: n = 16'h0400;
            3'h6: n = 16'h0800;
            default: n = 16'h1000;
        endcase
        return n;
    endfunction

endpackage

// [rtl/lcft_tick_if.sv]
// Carrier between the frame timing controller and its prescaler/divider
`timescale 1ns/1ps
interface lcft_tick_if;
    logic clear;
    logic src_tick;
    logic [2:0] tap_sel;
    logic [2:0] div_sel;
    logic period_start;
    logic half_point;
    modport ctrl (output clear, output src_tick, output tap_sel, output div_sel,
                  input period_start, input half_point);
    modport div (input clear, input src_tick, input tap_sel, input div_sel,
                 output period_start, output half_point);
endinterface

// [rtl/lcft_timing.sv]
// Frame rate and driver on-time controller with its AHB-Lite register slave
//
// Overview of operation
// - Reserved bits 7 and 3 of frame rate, bit 4 of drive register read zero.
// - Tap codes 0 to 7 divide the source clock by 16 up to 4096.
// - Divide field plus one gives the extra division D, 1 to 8.
// - Prescaled display clock is tap output divided by D; it clocks the display.
// - Static, half and quarter duty: one frame per 8 prescaled periods.
// - Third duty: one frame per 6 prescaled periods.
// - Drive code picks 300,70,150,450,575,850,1150 us, or half period for 7.
// - Driver on-time never exceeds half a prescaled clock period.
// - Static duty or blanking: driver on exactly half period, drive code ignored.
// - A new drive code takes effect at once, not at a frame boundary.
// - Real on-time may exceed nominal; nominal is a lower bound.
// - Duty codes 0 to 3 select static, half, third, quarter duty.
// - Source select zero uses the system clock, one the external clock.
// - Contrast field writes take effect at the next frame start.
// - Once blanking is active and the frame ends, segments_grounded goes high; clock and driver keep running.
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module lcft_timing #(
    parameter int unsigned DRV_CYC_C0 = lcft_pkg::DRV_CYC_C0,
    parameter int unsigned DRV_CYC_C1 = lcft_pkg::DRV_CYC_C1,
    parameter int unsigned DRV_CYC_C2 = lcft_pkg::DRV_CYC_C2,
    parameter int unsigned DRV_CYC_C3 = lcft_pkg::DRV_CYC_C3,
    parameter int unsigned DRV_CYC_C4 = lcft_pkg::DRV_CYC_C4,
    parameter int unsigned DRV_CYC_C5 = lcft_pkg::DRV_CYC_C5,
    parameter int unsigned DRV_CYC_C6 = lcft_pkg::DRV_CYC_C6
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ext_clk,
    output logic divided_display_clock,
    output logic frame_start,
    output logic driver_on,
    output logic [3:0] contrast_level,
    output logic [1:0] duty_select,
    output logic segments_grounded
);
    // Registers
    logic [7:0] frame_rate_q;
    logic [7:0] drive_contrast_q;
    logic [7:0] control_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;

    // Bus data phase state
    logic wr_pend_q;
    logic [11:0] wr_addr_q;
    logic addr_phase;
    logic [7:0] rd_val;

    // Source clock crossing
    logic ext_meta_q;
    logic ext_sync_q;
    logic ext_prev_q;
    logic src_tick;

    // Timing state
    logic ps_clk_q;
    logic frame_start_q;
    logic [2:0] period_cnt_q;
    logic [3:0] frame_k;
    logic driver_on_q;
    logic [15:0] drv_cnt_q;
    logic [15:0] drv_target;
    logic half_mode;
    logic [3:0] contrast_q;
    logic blanked_q;

    logic en;
    logic blank_req;
    logic [1:0] duty;
    logic [2:0] drv_sel;

    lcft_tick_if tk ();

    lcft_divider u_divider (
        .hclk(hclk),
        .hresetn(hresetn),
        .tk(tk)
    );

    assign en = control_q[lcft_pkg::CT_ENABLE];
    assign blank_req = control_q[lcft_pkg::CT_BLANK];
    assign duty = control_q[lcft_pkg::CT_DUTY_LSB +: 2];
    assign drv_sel = drive_contrast_q[lcft_pkg::DRV_LSB +: 3];

    // ---------------- AHB-Lite slave ----------------
    assign addr_phase = hsel && hready && (htrans == lcft_pkg::HTRANS_NONSEQ || htrans[1]);

    always_comb begin
        rd_val = 8'h00;
        case (haddr[11:0])
            lcft_pkg::ADDR_FRAME_RATE: rd_val = frame_rate_q & lcft_pkg::FRAME_RATE_WMASK;
            lcft_pkg::ADDR_DRIVE_CONTRAST:
                rd_val = drive_contrast_q & lcft_pkg::DRIVE_CONTRAST_WMASK;
            lcft_pkg::ADDR_CONTROL: begin
                rd_val = control_q & lcft_pkg::CONTROL_WMASK;
                rd_val[lcft_pkg::CT_BLANKED] = blanked_q;
            end
            default: rd_val = 8'h00;
        endcase
    end

    // Address phase capture; read data is ready for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
            hrdata_q <= 32'h0000_0000;
        end else begin
            wr_pend_q <= addr_phase && hwrite;
            if (addr_phase) begin
                wr_addr_q <= haddr[11:0];
            end
            if (addr_phase && !hwrite) begin
                hrdata_q <= {24'h00_0000, rd_val};
            end
        end
    end

    // Never stalls and never errors
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end

    // Register writes in the data phase; unmapped addresses are ignored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame_rate_q <= lcft_pkg::FRAME_RATE_RST;
            drive_contrast_q <= lcft_pkg::DRIVE_CONTRAST_RST;
            control_q <= lcft_pkg::CONTROL_RST;
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                lcft_pkg::ADDR_FRAME_RATE:
                    frame_rate_q <= hwdata[7:0] & lcft_pkg::FRAME_RATE_WMASK;
                lcft_pkg::ADDR_DRIVE_CONTRAST:
                    drive_contrast_q <= hwdata[7:0] & lcft_pkg::DRIVE_CONTRAST_WMASK;
                lcft_pkg::ADDR_CONTROL:
                    control_q <= hwdata[7:0] & lcft_pkg::CONTROL_WMASK;
                default: control_q <= control_q;
            endcase
        end
    end

    // ---------------- Source clock selection ----------------
    // External clock is sampled, so it must stay well below half of hclk
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end else begin
            ext_meta_q <= ext_clk;
            ext_sync_q <= ext_meta_q;
            ext_prev_q <= ext_sync_q;
        end
    end

    assign src_tick = control_q[lcft_pkg::CT_SOURCE] ? (ext_sync_q && !ext_prev_q) : 1'b1;

    assign tk.clear = !en;
    assign tk.src_tick = src_tick;
    assign tk.tap_sel = frame_rate_q[lcft_pkg::TAP_LSB +: 3];
    assign tk.div_sel = frame_rate_q[lcft_pkg::DIV_LSB +: 3];

    // ---------------- Prescaled clock ----------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ps_clk_q <= 1'b0;
        end else if (!en) begin
            ps_clk_q <= 1'b0;
        end else if (tk.period_start) begin
            ps_clk_q <= 1'b1;
        end else if (tk.half_point) begin
            ps_clk_q <= 1'b0;
        end
    end

    // ---------------- Frame timing ----------------
    assign frame_k = (duty == lcft_pkg::DUTY_THIRD) ? lcft_pkg::FRAME_K_THIRD
                                                    : lcft_pkg::FRAME_K_DEFAULT;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            period_cnt_q <= 3'h0;
            frame_start_q <= 1'b0;
        end else if (!en) begin
            period_cnt_q <= 3'h0;
            frame_start_q <= 1'b0;
        end else begin
            frame_start_q <= 1'b0;
            if (tk.period_start) begin
                // A shorter duty chosen with the count at or past its last period ends the frame at the next period start
                if ({1'b0, period_cnt_q} >= frame_k - 4'h1) begin
                    period_cnt_q <= 3'h0;
                    frame_start_q <= 1'b1;
                end else begin
                    period_cnt_q <= period_cnt_q + 3'h1;
                end
            end
        end
    end

    // Frame-boundary updates of contrast and blanking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            contrast_q <= 4'h0;
            blanked_q <= 1'b0;
        end else if (frame_start_q) begin
            contrast_q <= drive_contrast_q[lcft_pkg::CON_LSB +: 4];
            blanked_q <= blank_req;
        end
    end

    // ---------------- Driver on-time ----------------
    assign half_mode = (duty == lcft_pkg::DUTY_STATIC) || blanked_q
                       || (drv_sel == lcft_pkg::DRV_HALF_CODE);

    always_comb begin
        case (drv_sel)
            3'h0: drv_target = 16'(DRV_CYC_C0);
            3'h1: drv_target = 16'(DRV_CYC_C1);
            3'h2: drv_target = 16'(DRV_CYC_C2);
            3'h3: drv_target = 16'(DRV_CYC_C3);
            3'h4: drv_target = 16'(DRV_CYC_C4);
            3'h5: drv_target = 16'(DRV_CYC_C5);
            3'h6: drv_target = 16'(DRV_CYC_C6);
            default: drv_target = 16'hFFFF;
        endcase
    end

    // On at each period start; off at nominal expiry or at mid-period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            driver_on_q <= 1'b0;
            drv_cnt_q <= 16'h0000;
        end else if (!en) begin
            driver_on_q <= 1'b0;
            drv_cnt_q <= 16'h0000;
        end else if (tk.period_start) begin
            driver_on_q <= 1'b1;
            drv_cnt_q <= 16'h0001;
        end else if (tk.half_point) begin
            driver_on_q <= 1'b0;
        end else if (driver_on_q) begin
            if (!half_mode && drv_cnt_q >= drv_target) begin
                driver_on_q <= 1'b0;
            end else if (drv_cnt_q != 16'hFFFF) begin
                drv_cnt_q <= drv_cnt_q + 16'h0001;
            end
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign divided_display_clock = ps_clk_q;
    assign frame_start = frame_start_q;
    assign driver_on = driver_on_q;
    assign contrast_level = contrast_q;
    assign duty_select = control_q[lcft_pkg::CT_DUTY_LSB +: 2];
    assign segments_grounded = blanked_q;

    // ---------------- Checks ----------------
    logic [15:0] chk_ticks_q;
    logic [3:0] chk_periods_q;
    logic chk_seen_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chk_ticks_q <= 16'h0000;
            chk_periods_q <= 4'h0;
            chk_seen_q <= 1'b0;
        end else if (!en || wr_pend_q) begin
            chk_ticks_q <= 16'h0000;
            chk_periods_q <= 4'h0;
            chk_seen_q <= 1'b0;
        end else begin
            if (tk.period_start) begin
                chk_ticks_q <= src_tick ? 16'h0001 : 16'h0000;
                chk_periods_q <= chk_periods_q + 4'h1;
            end else begin
                if (src_tick) begin
                    chk_ticks_q <= chk_ticks_q + 16'h0001;
                end
                // Strobe trails its period pulse by a cycle, so recount here
                if (frame_start_q) begin
                    chk_periods_q <= 4'h0;
                end
            end
            if (frame_start_q) begin
                chk_seen_q <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    reserved_zero_a: assert property (
        (addr_phase && !hwrite && haddr[11:0] == lcft_pkg::ADDR_FRAME_RATE)
        |=> (hrdata_q[7] == 1'b0 && hrdata_q[3] == 1'b0))
        else $error("reserved frame rate bits read nonzero");

    period_length_a: assert property (
        (tk.period_start && en && !wr_pend_q && $stable(frame_rate_q) && chk_seen_q)
        |-> (chk_ticks_q == lcft_pkg::tap_ratio(tk.tap_sel)
             * ({13'h0000, tk.div_sel} + 16'h0001)))
        else $error("prescaled period differs from N times D");

    frame_len_a: assert property (
        (frame_start_q && chk_seen_q && $stable(control_q))
        |-> (chk_periods_q == frame_k))
        else $error("frame length does not match duty");

    drive_max_a: assert property (
        tk.half_point |=> !driver_on_q)
        else $error("driver on past half period");

    static_half_a: assert property (
        (driver_on_q && half_mode && !tk.half_point && en && $stable(control_q))
        |=> driver_on_q)
        else $error("driver cut short in half-period mode");

    drive_nominal_a: assert property (
        ($fell(driver_on_q) && !$past(half_mode) && $past(en) && !$past(tk.half_point))
        |-> ($past(drv_cnt_q) >= $past(drv_target)))
        else $error("driver released before nominal time");

    contrast_frame_a: assert property (
        $changed(contrast_q) |-> $past(frame_start_q))
        else $error("contrast changed off a frame boundary");

    blank_ground_a: assert property (
        (frame_start_q && blank_req) |=> segments_grounded ##1 segments_grounded)
        else $error("blanking not applied after frame end");

    disabled_idle_a: assert property (
        !en |=> (!frame_start_q && !driver_on_q && !ps_clk_q))
        else $error("timing active while disabled");

    frame_strobe_a: assert property (
        frame_start_q |=> !frame_start_q [*4])
        else $error("frame strobe longer than one cycle");

endmodule // lcft_timing

// [testbench/tb_top.sv]
// Self-checking bench for the display frame timing block
`timescale 1ns/1ps
module tb_top;
    localparam logic [11:0] A_FR = lcft_pkg::ADDR_FRAME_RATE;
    localparam logic [11:0] A_DC = lcft_pkg::ADDR_DRIVE_CONTRAST;
    localparam logic [11:0] A_CT = lcft_pkg::ADDR_CONTROL;
    // Small on-time counts for codes 0 to 4; codes 5 and 6 keep their long defaults
    localparam int DRV [7] = '{3, 1, 2, 4, 9, int'(lcft_pkg::DRV_CYC_C5),
        int'(lcft_pkg::DRV_CYC_C6)};
    logic hclk, hresetn, hsel, hwrite, ext_clk, ext_run;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, duty_select, ext_cnt;
    logic [2:0] hsize;
    logic hreadyout, hresp, divided_display_clock, frame_start, driver_on, segments_grounded;
    logic [3:0] contrast_level;
    int miscompares, num_checks, hi, per, k, n, lo;

    lcft_timing #(.DRV_CYC_C0(3), .DRV_CYC_C1(1), .DRV_CYC_C2(2), .DRV_CYC_C3(4),
        .DRV_CYC_C4(9)) u_lcft_timing (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_clk(ext_clk),
        .divided_display_clock(divided_display_clock), .frame_start(frame_start),
        .driver_on(driver_on), .contrast_level(contrast_level), .duty_select(duty_select),
        .segments_grounded(segments_grounded));

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    // External source at a quarter of the bus clock
    always @(posedge hclk) begin
        if (ext_run) begin
            ext_cnt <= ext_cnt + 2'h1;
            ext_clk <= ext_cnt[1];
        end
    end

    task automatic give_verdict;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    // Single word transfer; entered and left just after a rising edge
    task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= lcft_pkg::HTRANS_NONSEQ;
        haddr <= {20'h00000, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [7:0] e, input string nm);
        bus(1'b0, a, 8'h00);
        chk(nm, {24'h000000, e}, rd);
    endtask

    function automatic logic sig(input int s);
        return s == 0 ? driver_on : (s == 1 ? divided_display_clock : frame_start);
    endfunction

    // High time and rise-to-rise period of one output, in bus cycles
    task automatic meas(input int s);
        while (sig(s) === 1'b1) @(posedge hclk);
        while (sig(s) !== 1'b1) @(posedge hclk);
        hi = 0;
        while (sig(s) === 1'b1) begin
            @(posedge hclk);
            hi++;
        end
        per = hi;
        while (sig(s) !== 1'b1) begin
            @(posedge hclk);
            per++;
        end
    endtask

    // Disable first so the counters restart cleanly on the new setting
    task automatic cfg(input int tap, input int dv, input int dut, input int src);
        bus(1'b1, A_CT, 8'h00);
        bus(1'b1, A_FR, 8'(tap * 16 + dv));
        bus(1'b1, A_DC, 8'h00);
        bus(1'b1, A_CT, 8'(1 + dut * 4 + src * 16));
        // Let the enable write land before any output is read
        @(posedge hclk);
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        ext_run = 1'b0;
        ext_clk = 1'b0;
        ext_cnt = 2'h0;
        miscompares = 0;
        num_checks = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk(A_FR, 8'h00, "frame_rate_reset");
        rdchk(A_DC, 8'h00, "drive_reset");
        rdchk(A_CT, 8'h00, "control_reset");
        bus(1'b1, A_FR, 8'hFF);
        rdchk(A_FR, 8'h77, "frame_rate_reserved");
        bus(1'b1, A_DC, 8'hFF);
        rdchk(A_DC, 8'hEF, "drive_reserved");
        bus(1'b1, A_CT, 8'hE0);
        rdchk(A_CT, 8'h00, "control_read_only");
        bus(1'b1, 12'h3A4, 8'hFF);
        rdchk(12'h3A4, 8'h00, "unmapped");
        // Every tap and divide code once, frames only where short
        for (int i = 0; i < 8; i++) begin
            n = (i == 0) ? 16 : (64 << (i - 1));
            cfg(i, 7 - i, i % 4, 0);
            chk("duty_select", 32'(i % 4), {30'h0, duty_select});
            meas(1);
            chk("ps_period", n * (8 - i), per);
            chk("ps_high", n * (8 - i) / 2, hi);
            if (i < 3) begin
                meas(2);
                chk("frame_period", (i == 2 ? 6 : 8) * n * (8 - i), per);
                chk("frame_pulse", 1, hi);
            end
        end
        // Drive codes changed on the fly; half period is 8 cycles here
        cfg(0, 0, 3, 0);
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, A_DC, 8'(c * 32));
            meas(0);
            lo = (c == 7) ? 8 : (DRV[c] > 8 ? 8 : DRV[c]);
            chk("drive_width_ok", 1, 32'(hi >= lo && hi <= 8));
        end
        bus(1'b1, A_DC, 8'h20);
        bus(1'b1, A_CT, 8'h01);
        meas(0);
        chk("static_drive", 8, hi);
        bus(1'b1, A_CT, 8'h0D);
        meas(2);
        bus(1'b1, A_DC, 8'h25);
        chk("contrast_held", 0, {28'h0, contrast_level});
        bus(1'b1, A_CT, 8'h0F);
        chk("blank_held", 0, {31'h0, segments_grounded});
        meas(2);
        chk("contrast_applied", 5, {28'h0, contrast_level});
        chk("blanked", 1, {31'h0, segments_grounded});
        rdchk(A_CT, 8'h8F, "blank_status");
        bus(1'b1, A_DC, 8'h45);
        meas(0);
        chk("blank_drive", 8, hi);
        bus(1'b1, A_CT, 8'h00);
        k = 0;
        repeat (2) @(posedge hclk);
        repeat (300) begin
            @(posedge hclk);
            if (divided_display_clock !== 1'b0 || frame_start !== 1'b0)
                k++;
        end
        chk("disabled_quiet", 0, k);
        ext_run <= 1'b1;
        cfg(0, 0, 3, 1);
        meas(1);
        meas(1);
        chk("ext_period", 64, per);
        chk("hresp_okay", 0, {31'h0, hresp});
        give_verdict();
    end

    // Planned run is about 49000 cycles
    initial begin
        repeat (90000) @(posedge hclk);
        miscompares++;
        give_verdict();
    end
endmodule // tb_top
